/* File: logic/tsbc_flag.v */
// One sticky new-result flag.
// Assumes set and clear are one-cycle pulses on core_clk.
`default_nettype none

module tsbc_flag (
    input wire core_clk,
    input wire srst,
    input wire set_pulse,
    input wire clear_pulse,
    output reg flag_reg
);

    // Set beats a clear in the same cycle so no result goes unseen
    always @(posedge core_clk) begin
        if (srst) begin
            flag_reg <= 1'b0;
        end else if (set_pulse) begin
            flag_reg <= 1'b1;
        end else if (clear_pulse) begin
            flag_reg <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: logic/tsbc_top.v */
// Status and buffer-control registers of the touch-screen SAR ADC.
// Assumes the serial control port delivers one-cycle read and write
// strobes with an 8-bit register address, and that the conversion
// engine and result registers give one-cycle done and read pulses.
`include "tsbc_regs.vh"
`default_nettype none

module tsbc_top #(
    parameter DEPTH = `TSBC_BUF_DEPTH,
    parameter PTR_W = 6
) (
    input wire core_clk,
    input wire srst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire [7:0] reg_wdata,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire pen_touch,
    input wire conv_busy,
    input wire [`TSBC_NUM_MEAS-1:0] conv_done,
    input wire [`TSBC_NUM_MEAS-1:0] result_read,
    input wire buf_push,
    input wire buf_pop,
    output reg buffer_enable,
    output reg buffer_single_shot,
    output reg [2:0] trigger_level,
    output reg [PTR_W-1:0] buffer_read_pointer,
    output reg [PTR_W-1:0] buffer_write_pointer,
    output reg [PTR_W:0] buffer_trigger_pointer,
    output reg buffer_trigger_hit,
    output reg buffer_accept
);

    // ****************************************
    // Per-measurement new-result flags
    // ****************************************
    wire [`TSBC_NUM_MEAS-1:0] new_flag;

    genvar gi;
    generate
        for (gi = 0; gi < `TSBC_NUM_MEAS; gi = gi + 1) begin : g_flag
            tsbc_flag u_flag (
                .core_clk(core_clk),
                .srst(srst),
                .set_pulse(conv_done[gi]),
                .clear_pulse(result_read[gi]),
                .flag_reg(new_flag[gi])
            );
        end
    endgenerate

    // Summary drops only once every pending result is read
    wire any_new = |new_flag;

    // ****************************************
    // Registered status sources and writable bits
    // ****************************************
    reg pen_reg;
    reg idle_reg;
    reg ts_rsvd_reg;
    reg [2:0] aux_rsvd_reg;
    reg [7:0] reserved_a_reg;
    reg [7:0] reserved_b_reg;
    reg bc_rsvd_reg;
    reg [PTR_W:0] count_reg;
    reg full_reg;
    reg empty_reg;

    wire wr_ts = reg_wr && (reg_addr == `TSBC_OFS_TOUCH_STATUS);
    wire wr_aux = reg_wr && (reg_addr == `TSBC_OFS_AUX_STATUS);
    wire wr_bc = reg_wr && (reg_addr == `TSBC_OFS_BUFFER_CONTROL);

    always @(posedge core_clk) begin
        if (srst) begin
            pen_reg <= 1'b0;
            idle_reg <= 1'b1;
        end else begin
            pen_reg <= pen_touch;
            idle_reg <= ~conv_busy;
        end
    end

    // Only reserved and control bits take writes; status bits ignore them
    always @(posedge core_clk) begin
        if (srst) begin
            ts_rsvd_reg <= `TSBC_RST_TS_RSVD;
            aux_rsvd_reg <= `TSBC_RST_AUX_RSVD;
            reserved_a_reg <= `TSBC_RST_RESERVED;
            reserved_b_reg <= `TSBC_RST_RESERVED;
            buffer_enable <= 1'b0;
            buffer_single_shot <= 1'b0;
            trigger_level <= 3'h0;
            bc_rsvd_reg <= 1'b0;
        end else if (reg_wr) begin
            if (wr_ts) begin
                ts_rsvd_reg <= reg_wdata[`TSBC_TS_RSVD];
            end
            if (wr_aux) begin
                aux_rsvd_reg <=
                    reg_wdata[`TSBC_AUX_RSVD_HI:`TSBC_AUX_RSVD_LO];
            end
            if (reg_addr == `TSBC_OFS_RESERVED_A) begin
                reserved_a_reg <= reg_wdata;
            end
            if (reg_addr == `TSBC_OFS_RESERVED_B) begin
                reserved_b_reg <= reg_wdata;
            end
            if (wr_bc) begin
                buffer_enable <= reg_wdata[`TSBC_BC_ENABLE];
                buffer_single_shot <= reg_wdata[`TSBC_BC_SINGLE];
                trigger_level <=
                    reg_wdata[`TSBC_BC_LEVEL_HI:`TSBC_BC_LEVEL_LO];
                bc_rsvd_reg <= reg_wdata[`TSBC_BC_RSVD];
            end
        end
    end

    // ****************************************
    // Buffer pointers and occupancy
    // ****************************************
    localparam [PTR_W:0] TRIG_STEP_W = `TSBC_TRIG_STEP;
    wire [PTR_W:0] depth_w = DEPTH[PTR_W:0];
    wire [PTR_W:0] thresh_w =
        {1'b0, trigger_level, 3'h0} + TRIG_STEP_W;
    wire single_stop = buffer_single_shot && buffer_trigger_hit;
    // Mode write lands on this edge; accept must match the next cycle
    wire single_next = wr_bc ? reg_wdata[`TSBC_BC_SINGLE] :
        buffer_single_shot;
    wire do_push = buffer_enable && buf_push && !full_reg && !single_stop;
    wire do_pop = buffer_enable && buf_pop && !empty_reg;
    reg [PTR_W:0] count_next;

    always @* begin
        count_next = count_reg;
        if (do_push && !do_pop) begin
            count_next = count_reg + 1'b1;
        end else if (do_pop && !do_push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Disable forces pointers home; unread contents are lost
    always @(posedge core_clk) begin
        if (srst || !buffer_enable) begin
            buffer_read_pointer <= {PTR_W{1'b0}};
            buffer_write_pointer <= {PTR_W{1'b0}};
            buffer_trigger_pointer <= {(PTR_W+1){1'b0}};
            count_reg <= {(PTR_W+1){1'b0}};
            full_reg <= 1'b0;
            empty_reg <= 1'b1;
            buffer_trigger_hit <= 1'b0;
            buffer_accept <= 1'b0;
        end else begin
            if (do_push) begin
                buffer_write_pointer <= buffer_write_pointer + 1'b1;
            end
            if (do_pop) begin
                buffer_read_pointer <= buffer_read_pointer + 1'b1;
            end
            buffer_trigger_pointer <= thresh_w;
            count_reg <= count_next;
            full_reg <= (count_next == depth_w);
            empty_reg <= (count_next == {(PTR_W+1){1'b0}});
            buffer_trigger_hit <= (count_next >= thresh_w);
            // Single-shot freezes the fill once the threshold is met
            buffer_accept <= (count_next != depth_w) &&
                !(single_next && (count_next >= thresh_w));
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    // Flags keep running in buffer mode; their values are meaningless then
    always @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `TSBC_OFS_TOUCH_STATUS: reg_rdata <= {pen_reg, idle_reg,
                    any_new, ts_rsvd_reg, new_flag[`TSBC_M_X],
                    new_flag[`TSBC_M_Y], new_flag[`TSBC_M_P1],
                    new_flag[`TSBC_M_P2]};
                `TSBC_OFS_AUX_STATUS: reg_rdata <= {new_flag[`TSBC_M_AUXILIARY_INPUT_ONE],
                    new_flag[`TSBC_M_AUXILIARY_INPUT_TWO], new_flag[`TSBC_M_BAT],
                    aux_rsvd_reg, new_flag[`TSBC_M_TEMPERATURE_ONE],
                    new_flag[`TSBC_M_TEMPERATURE_TWO]};
                `TSBC_OFS_RESERVED_A: reg_rdata <= reserved_a_reg;
                `TSBC_OFS_RESERVED_B: reg_rdata <= reserved_b_reg;
                `TSBC_OFS_BUFFER_CONTROL: reg_rdata <= {buffer_enable,
                    buffer_single_shot, trigger_level, bc_rsvd_reg,
                    full_reg, empty_reg};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

`default_nettype wire

/* File: pkg/tsbc_regs.vh */
// Offsets, field positions, reset values and sizes of the touch ADC
// status and buffer-control registers.
// Assumes inclusion by bare name from the design files.
//
// Function
// - Pen contact reads on a read-only bit reset to 0, and a second bit reset to 1 reads 0 while the converter is busy.
// - A summary new-result flag is set when results exist and clears only when every pending result has been read.
// - X, Y, first and second pressure each have a new-result flag that clears only when its own result is read.
// - A second status register holds new-result flags for two auxiliary inputs, battery and two temperatures.
// - All new-result flags carry no meaning while buffer mode is enabled.
// - With the buffer enable bit at 0 the read, write and trigger pointers stay at their defaults.
// - The mode select bit picks continuous conversion at 0 and single-shot at 1.
// - A three-bit trigger level sets the threshold at 8 times the code plus eight results.
// - A read-only full flag reset to 0 reads 1 when 64 unread results sit in the buffer.
// - A read-only empty flag reset to 1 reads 1 whenever no unread result is in the buffer.
`ifndef TSBC_REGS_VH
`define TSBC_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define TSBC_OFS_TOUCH_STATUS 8'h09
`define TSBC_OFS_AUX_STATUS 8'h0A
`define TSBC_OFS_RESERVED_A 8'h0B
`define TSBC_OFS_RESERVED_B 8'h0C
`define TSBC_OFS_BUFFER_CONTROL 8'h0D

// ****************************************
// Field positions
// ****************************************
`define TSBC_TS_PEN 7
`define TSBC_TS_IDLE 6
`define TSBC_TS_ANY 5
`define TSBC_TS_RSVD 4
`define TSBC_AUX_RSVD_HI 4
`define TSBC_AUX_RSVD_LO 2
`define TSBC_BC_ENABLE 7
`define TSBC_BC_SINGLE 6
`define TSBC_BC_LEVEL_HI 5
`define TSBC_BC_LEVEL_LO 3
`define TSBC_BC_RSVD 2
`define TSBC_BC_FULL 1
`define TSBC_BC_EMPTY 0

// ****************************************
// Measurement indices of the new-result flags
// ****************************************
`define TSBC_M_X 0
`define TSBC_M_Y 1
`define TSBC_M_P1 2
`define TSBC_M_P2 3
`define TSBC_M_AUXILIARY_INPUT_ONE 4
`define TSBC_M_AUXILIARY_INPUT_TWO 5
`define TSBC_M_BAT 6
`define TSBC_M_TEMPERATURE_ONE 7
`define TSBC_M_TEMPERATURE_TWO 8
`define TSBC_NUM_MEAS 9

// ****************************************
// Reset values and sizes
// ****************************************
`define TSBC_RST_RESERVED 8'h00
`define TSBC_RST_TS_RSVD 1'h0
`define TSBC_RST_AUX_RSVD 3'h0
`define TSBC_RST_BC_CTRL 5'h00
`define TSBC_BUF_DEPTH 64
`define TSBC_TRIG_STEP 8

`endif

/* File: sim/test_touch_adc_status_buffer_ctrl.sv */
// Self-checking bench for the status and buffer-control registers.
// Assumes tsbc_host drives the register port.
`default_nettype none
module test_touch_adc_status_buffer_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0, srst = 1'b1, pen_touch = 1'b0, conv_busy = 1'b0;
    logic buf_push = 1'b0, buf_pop = 1'b0, reg_wr, reg_rd;
    logic [8:0] conv_done = 9'h000, result_read = 9'h000, f = 9'h000;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic buffer_enable, buffer_single_shot, buffer_trigger_hit;
    logic buffer_accept;
    logic [2:0] trigger_level;
    logic [5:0] buffer_read_pointer, buffer_write_pointer;
    logic [6:0] buffer_trigger_pointer;
    logic [31:0] seed = 32'hC4BE;
    int errors = 0, tests_run = 0, cyc = 0;
    tsbc_top dut_u (.core_clk, .srst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rd, .reg_rdata, .pen_touch, .conv_busy, .conv_done,
        .result_read, .buf_push, .buf_pop, .buffer_enable,
        .buffer_single_shot, .trigger_level, .buffer_read_pointer,
        .buffer_write_pointer, .buffer_trigger_pointer,
        .buffer_trigger_hit, .buffer_accept);
    tsbc_host host_u (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata);
    // ****
    // Helpers
    // ****
    function automatic logic [7:0] exp_ts(input logic [8:0] g);
        return {pen_touch, !conv_busy, |g, 1'b0, g[0], g[1], g[2], g[3]};
    endfunction
    function automatic logic [7:0] exp_aux(input logic [8:0] g);
        return {g[4], g[5], g[6], 3'h0, g[7], g[8]};
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bufop(input int n, input logic p, input logic q);
        repeat (n) begin
            @(negedge core_clk);
            buf_push = p;
            buf_pop = q;
        end
        @(negedge core_clk);
        buf_push = 1'b0;
        buf_pop = 1'b0;
        @(negedge core_clk);
    endtask
    initial forever #4 core_clk = ~core_clk;
    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            errors = errors + 1;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(negedge core_clk);
        srst = 1'b0;
        for (int i = 8; i < 15; i++) begin
            host_u.rd(i[7:0], rv);
            chk(rv, i == 9 ? 8'h40 : i == 13 ? 8'h01 : 8'h00);
        end
        host_u.wr(8'h09, 8'hFF);
        host_u.wr(8'h0A, 8'hFF);
        host_u.rd(8'h09, rv);
        chk(rv, 8'h40);
        $display("test reset_values done");
        // Last pass clears every flag so the summary must drop
        for (int k = 0; k < 24; k++) begin
            seed = xs(seed);
            @(negedge core_clk);
            conv_done = k == 23 ? 9'h000 : seed[8:0];
            result_read = k == 23 ? 9'h1FF : seed[17:9];
            pen_touch = seed[20];
            conv_busy = seed[21];
            f = (f & ~result_read) | conv_done;
            @(negedge core_clk);
            conv_done = 9'h000;
            result_read = 9'h000;
            host_u.rd(8'h09, rv);
            chk(rv, exp_ts(f));
            host_u.rd(8'h0A, rv);
            chk(rv, exp_aux(f));
        end
        $display("test flags done");
        host_u.wr(8'h0D, 8'hB8);
        bufop(65, 1'b1, 1'b0);
        chk({2'h0, buffer_write_pointer}, 8'h00);
        chk({7'h00, buffer_accept}, 8'h00);
        host_u.rd(8'h0D, rv);
        chk(rv, 8'hBA);
        bufop(65, 1'b0, 1'b1);
        chk({2'h0, buffer_read_pointer}, 8'h00);
        chk({7'h00, buffer_trigger_hit}, 8'h00);
        host_u.rd(8'h0D, rv);
        chk(rv, 8'hB9);
        host_u.wr(8'h0D, 8'hC0);
        bufop(12, 1'b1, 1'b0);
        chk({2'h0, buffer_write_pointer}, 8'h08);
        chk({7'h00, buffer_trigger_hit}, 8'h01);
        chk({7'h00, buffer_accept}, 8'h00);
        host_u.wr(8'h0D, 8'h00);
        bufop(1, 1'b1, 1'b0);
        chk({2'h0, buffer_write_pointer}, 8'h00);
        host_u.rd(8'h0D, rv);
        chk(rv, 8'h01);
        for (int l = 0; l < 8; l++) begin
            host_u.wr(8'h0D, {2'b10, l[2:0], 3'h0});
            @(negedge core_clk);
            chk({1'b0, buffer_trigger_pointer}, 8'(l * 8 + 8));
        end
        $display("test buffer done");
        print_verdict();
    end
endmodule
bind tsbc_top tsbc_top_sva #(.PTR_W(PTR_W)) chk_u (.core_clk, .srst,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .pen_touch,
    .conv_busy, .buf_push, .buf_pop, .buffer_enable, .buffer_single_shot,
    .trigger_level, .buffer_read_pointer, .buffer_write_pointer,
    .buffer_trigger_pointer, .buffer_trigger_hit, .buffer_accept);
`default_nettype wire

/* File: sim/tsbc_host.sv */
// Host model driving the register port of the control interface.
// Assumes strobes change at falling edges of core_clk.
`default_nettype none
module tsbc_host (
    input wire logic core_clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h09) d[4] = 1'b0;
        if (a == 8'h0A) d[4:2] = 3'h0;
        if (a == 8'h0B || a == 8'h0C) d = 8'h00;
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

/* File: sim/tsbc_top_sva.sv */
// Assertions on the status and buffer-control register block.
// Assumes a bind into tsbc_top; sees only its ports.
`default_nettype none
module tsbc_top_sva #(
    parameter PTR_W = 6
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic pen_touch,
    input wire logic conv_busy,
    input wire logic buf_push,
    input wire logic buf_pop,
    input wire logic buffer_enable,
    input wire logic buffer_single_shot,
    input wire logic [2:0] trigger_level,
    input wire logic [PTR_W-1:0] buffer_read_pointer,
    input wire logic [PTR_W-1:0] buffer_write_pointer,
    input wire logic [PTR_W:0] buffer_trigger_pointer,
    input wire logic buffer_trigger_hit,
    input wire logic buffer_accept
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // Properties
    // ****
    wire ctl = reg_wr && reg_addr == 8'h0D;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Pointers lag the enable bit by one cycle
    a_ptr_idle: assert property (
        !buffer_enable [*3] |-> buffer_read_pointer == 0
        && buffer_write_pointer == 0 && buffer_trigger_pointer == 0
        && !buffer_accept && !buffer_trigger_hit) else $error("ptr idle");
    a_trig_level: assert property (
        buffer_enable && $past(buffer_enable) && $stable(trigger_level)
        |-> buffer_trigger_pointer == (trigger_level + 4'h1) * 4'h8)
        else $error("trig ptr");
    a_ctl_write: assert property (
        ctl |=> {buffer_enable, buffer_single_shot, trigger_level}
        == $past(reg_wdata[7:3])) else $error("ctl write");
    a_ctl_read: assert property (
        !reg_wr && reg_rd && reg_addr == 8'h0D |=> reg_rdata[7:3] ==
        {$past(buffer_enable), $past(buffer_single_shot),
        $past(trigger_level)}) else $error("ctl read");
    a_pen_read: assert property (
        reg_rd && reg_addr == 8'h09 |=> reg_rdata[7:6] ==
        {$past(pen_touch, 2), !$past(conv_busy, 2)}) else $error("pen");
    a_push_step: assert property (
        buf_push && !buf_pop && buffer_accept && buffer_enable && !ctl
        |=> buffer_write_pointer == $past(buffer_write_pointer) + 1'b1)
        else $error("push");
    a_pop_empty: assert property (
        buf_pop && !buf_push && buffer_accept && buffer_enable && !ctl
        && buffer_read_pointer == buffer_write_pointer
        |=> $stable(buffer_read_pointer)) else $error("pop empty");
    a_single_stop: assert property (
        buffer_enable && buffer_single_shot && buffer_trigger_hit
        && $stable(buffer_single_shot) |-> !buffer_accept)
        else $error("single");
endmodule
`default_nettype wire
